// *** ppp_pkg.sv ***
// Constants, encodings and layouts for the parallel programming port.
// Assumes a single 100 MHz clock and pins already synchronous to it.
//
// Contract
// - Load strobe action set by select pins
// - Write/read strobe runs command; erase, fuse, lock
// - Decode flash write, EEPROM write, EEPROM read
// - Decode signature, fuse/lock and flash reads
// - Ready/busy low while programming runs
// - Drive data bus only while output enable low
// - First byte select picks low/high byte
// - Second byte select picks extended high byte
// - Page latch strobe loads page buffer
// - Fuses latched at entry, applied at exit
// - EEPROM keep fuse acts immediately
// - Fuses latched at power-up in normal mode
// - Erase keeps fuses; keep fuse saves EEPROM
// - Fuse writes refused while first lock set
// - Serial prog fuse changeable only here
// - Low config byte field layout, RC default
// - Three-byte signature readable even locked
// - Calibration byte copied to trim at reset
// - Flash 128 pages of 64 words
// - EEPROM 128 pages of 4 bytes
// - Programmed bit reads as zero
// - Erase starts on write strobe, busy low
package ppp_pkg;

   // Clock and timing
   localparam int CLK_MHZ          = 100;
   localparam int MIN_PULSE_NS     = 250;
   localparam int MIN_PULSE_CYC    = (MIN_PULSE_NS * CLK_MHZ + 999) / 1000;
   localparam int WRITE_TIME_NS    = 2000;
   localparam int WRITE_CYC        = (WRITE_TIME_NS * CLK_MHZ) / 1000;

   // Action select coding
   localparam logic [1:0] ACT_ADDR = 2'h0;
   localparam logic [1:0] ACT_DATA = 2'h1;
   localparam logic [1:0] ACT_CMD  = 2'h2;
   localparam logic [1:0] ACT_IDLE = 2'h3;

   // Command byte coding
   localparam logic [7:0] CMD_NOP       = 8'h00;
   localparam logic [7:0] CMD_ERASE     = 8'h80;
   localparam logic [7:0] CMD_WR_FUSE   = 8'h40;
   localparam logic [7:0] CMD_WR_LOCK   = 8'h20;
   localparam logic [7:0] CMD_WR_FLASH  = 8'h10;
   localparam logic [7:0] CMD_WR_EE     = 8'h11;
   localparam logic [7:0] CMD_RD_SIG    = 8'h08;
   localparam logic [7:0] CMD_RD_FUSE   = 8'h04;
   localparam logic [7:0] CMD_RD_FLASH  = 8'h02;
   localparam logic [7:0] CMD_RD_EE     = 8'h03;

   // Config byte field positions
   localparam int HI_ONCHIP_DEBUG  = 7;
   localparam int HI_SCAN_PORT     = 6;
   localparam int HI_SERIAL_PROG   = 5;
   localparam int HI_WDOG_FORCE    = 4;
   localparam int HI_EEPROM_KEEP   = 3;
   localparam int LO_CLOCK_DIV     = 7;
   localparam int LO_CLOCK_OUT     = 6;
   localparam int LO_STARTUP_MSB   = 5;
   localparam int LO_STARTUP_LSB   = 4;
   localparam int LO_CLKSRC_MSB    = 3;
   localparam int LO_CLKSRC_LSB    = 0;

   // Reset values; zero means programmed
   localparam logic [7:0] CFG_HI_RST   = 8'h99;
   localparam logic [7:0] CFG_LO_RST   = 8'h62;
   localparam logic [7:0] LOCK_RST     = 8'hFF;
   localparam int         LOCK_FIRST   = 0;

   // Signature space
   localparam logic [1:0] SIG_ADDR_0   = 2'h0;
   localparam logic [1:0] SIG_ADDR_1   = 2'h1;
   localparam logic [1:0] SIG_ADDR_2   = 2'h2;

   // Memory geometry
   localparam int FLASH_WORD_BITS = 6;
   localparam int FLASH_PAGE_BITS = 7;
   localparam int EE_BYTE_BITS    = 2;
   localparam int EE_PAGE_BITS    = 7;

endpackage

// *** ppp_port.sv ***
// Device side of the parallel programming port: command, address and
// data loading, page buffers, fuse and lock store, signature reads.
// Assumes programmer pins are synchronous to mclk_i.
`timescale 1ns/1ns
`default_nettype none

module ppp_port
#(
   parameter int          WRITE_CYCLES = ppp_pkg::WRITE_CYC,
   parameter logic [7:0]  SIG_BYTE0    = 8'hA5, // Arbitrary identity
   parameter logic [7:0]  SIG_BYTE1    = 8'h5A, // Arbitrary identity
   parameter logic [7:0]  SIG_BYTE2    = 8'h3C, // Arbitrary identity
   parameter logic [7:0]  CAL_BYTE     = 8'h80
)
(
   // Clock and reset
   input  wire logic        mclk_i,
   input  wire logic        sys_rst_i,
   // Mode entry
   input  wire logic        prog_mode_i,
   // Programmer control pins
   input  wire logic        load_strobe_i,
   input  wire logic        action_select_hi_i,
   input  wire logic        action_select_lo_i,
   input  wire logic        byte_select_first_i,
   input  wire logic        byte_select_second_i,
   input  wire logic        page_latch_strobe_i,
   input  wire logic        write_n_i,
   input  wire logic        out_enable_n_i,
   // Bidirectional data bus
   input  wire logic [7:0]  data_i,
   output logic      [7:0]  data_o,
   output logic             data_oe_o,
   // Status
   output logic             ready_busy_out_o,
   // Effective fuse values seen by the rest of the chip
   output logic      [7:0]  cfg_hi_eff_o,
   output logic      [7:0]  cfg_lo_eff_o,
   output logic             eeprom_keep_o,
   output logic      [7:0]  osc_trim_register_o
);

   // Refuse a write time that the busy counter cannot count down
   if (WRITE_CYCLES < 1)
   begin : g_bad_write_cycles
      $error("WRITE_CYCLES must be at least one");
   end

   localparam int FA = ppp_pkg::FLASH_WORD_BITS + ppp_pkg::FLASH_PAGE_BITS;
   localparam int EA = ppp_pkg::EE_BYTE_BITS + ppp_pkg::EE_PAGE_BITS;

   typedef enum {PPP_IDLE, PPP_ERASE, PPP_WRITE} ppp_state_t;

   // Edge detection of strobes
   logic              load_d_r;
   logic              page_d_r;
   logic              wr_d_r;
   logic              oe_d_r;
   logic              mode_d_r;
   logic              load_rise;
   logic              page_rise;
   logic              wr_fall;
   logic              oe_fall;
   logic [1:0]        act;

   // Loaded command, address and data bytes
   logic [7:0]        cmd_r;
   logic [15:0]       addr_r;
   logic [7:0]        data_lo_r;
   logic [7:0]        data_hi_r;
   logic [7:0]        data_hi2_r;

   // Memories and page buffers
   logic [15:0]       flash_mem [0:(1<<FA)-1];
   logic [7:0]        ee_mem    [0:(1<<EA)-1];
   logic [15:0]       flash_buf [0:(1<<ppp_pkg::FLASH_WORD_BITS)-1];
   logic [7:0]        ee_buf    [0:(1<<ppp_pkg::EE_BYTE_BITS)-1];

   // Stored and latched fuse and lock bytes
   logic [7:0]        cfg_hi_r;
   logic [7:0]        cfg_lo_r;
   logic [7:0]        cfg_ext_r;
   logic [7:0]        lock_r;
   logic [7:0]        cfg_hi_eff_r;
   logic [7:0]        cfg_lo_eff_r;
   logic [7:0]        trim_r;

   // Busy sequencer
   ppp_state_t        state_r;
   logic [31:0]       cnt_r;
   logic [FA-1:0]     erase_idx_r;
   logic [7:0]        rd_r;

   assign act       = {action_select_hi_i, action_select_lo_i};
   assign load_rise = load_strobe_i & ~load_d_r;
   assign page_rise = page_latch_strobe_i & ~page_d_r;
   assign wr_fall   = ~write_n_i & wr_d_r;
   assign oe_fall   = ~out_enable_n_i & oe_d_r;

   // Strobe history registers
   always_ff @(posedge mclk_i)
   begin
      if (sys_rst_i)
      begin
         load_d_r <= 1'b0;
         page_d_r <= 1'b0;
         wr_d_r   <= 1'b1;
         oe_d_r   <= 1'b1;
         mode_d_r <= 1'b0;
      end
      else
      begin
         load_d_r <= load_strobe_i;
         page_d_r <= page_latch_strobe_i;
         wr_d_r   <= write_n_i;
         oe_d_r   <= out_enable_n_i;
         mode_d_r <= prog_mode_i;
      end
   end

   // Byte loading on load strobe; ignored while busy
   always_ff @(posedge mclk_i)
   begin
      if (sys_rst_i)
      begin
         cmd_r      <= ppp_pkg::CMD_NOP;
         addr_r     <= 16'h0000;
         data_lo_r  <= 8'hFF;
         data_hi_r  <= 8'hFF;
         data_hi2_r <= 8'hFF;
      end
      else if (prog_mode_i && load_rise && state_r == PPP_IDLE)
      begin
         case (act)
            ppp_pkg::ACT_ADDR:
               if (byte_select_first_i)
                  addr_r[15:8] <= data_i;
               else
                  addr_r[7:0] <= data_i;
            ppp_pkg::ACT_DATA:
               if (byte_select_second_i)
                  data_hi2_r <= data_i;
               else if (byte_select_first_i)
                  data_hi_r <= data_i;
               else
                  data_lo_r <= data_i;
            ppp_pkg::ACT_CMD:
               cmd_r <= data_i;
            default:
               cmd_r <= cmd_r;                                // Idle action
         endcase
      end
   end

   // Page buffer fill on page latch strobe
   always_ff @(posedge mclk_i)
   begin
      if (prog_mode_i && page_rise)
      begin
         if (cmd_r == ppp_pkg::CMD_WR_FLASH)
            flash_buf[addr_r[ppp_pkg::FLASH_WORD_BITS-1:0]] <=
               {data_hi_r, data_lo_r};
         else if (cmd_r == ppp_pkg::CMD_WR_EE)
            ee_buf[addr_r[ppp_pkg::EE_BYTE_BITS-1:0]] <= data_lo_r;
      end
   end

   // Command execution, busy timing, fuse and lock writes
   always_ff @(posedge mclk_i)
   begin
      if (sys_rst_i)
      begin
         state_r     <= PPP_IDLE;
         cnt_r       <= 32'h0000_0000;
         erase_idx_r <= '0;
         cfg_hi_r    <= ppp_pkg::CFG_HI_RST;
         cfg_lo_r    <= ppp_pkg::CFG_LO_RST;
         cfg_ext_r   <= 8'hFF;
         lock_r      <= ppp_pkg::LOCK_RST;
      end
      else
      begin
         case (state_r)
            PPP_IDLE:
               if (prog_mode_i && wr_fall)
               begin
                  cnt_r <= 32'(WRITE_CYCLES);
                  case (cmd_r)
                     ppp_pkg::CMD_ERASE:
                     begin
                        erase_idx_r <= '0;
                        state_r     <= PPP_ERASE;
                     end
                     ppp_pkg::CMD_WR_FUSE:
                     begin
                        state_r <= PPP_WRITE;
                        if (lock_r[ppp_pkg::LOCK_FIRST])
                        begin
                           // Parallel port may change every bit
                           if (byte_select_second_i)
                              cfg_ext_r <= data_lo_r;
                           else if (byte_select_first_i)
                              cfg_hi_r <= data_lo_r;
                           else
                              cfg_lo_r <= data_lo_r;
                        end
                     end
                     ppp_pkg::CMD_WR_LOCK:
                     begin
                        state_r <= PPP_WRITE;
                        lock_r  <= lock_r & data_lo_r;       // Only programs
                     end
                     ppp_pkg::CMD_WR_FLASH, ppp_pkg::CMD_WR_EE:
                        state_r <= PPP_WRITE;
                     default:
                        state_r <= PPP_IDLE;
                  endcase
               end
            PPP_ERASE:
            begin
               // Walks every flash word; fuses are never touched
               erase_idx_r <= erase_idx_r + 1'b1;
               if (&erase_idx_r)
               begin
                  lock_r  <= ppp_pkg::LOCK_RST;              // Locks last
                  state_r <= PPP_IDLE;
               end
            end
            PPP_WRITE:
            begin
               cnt_r <= cnt_r - 32'h0000_0001;
               if (cnt_r <= 32'h0000_0001)
                  state_r <= PPP_IDLE;
            end
            default:
               state_r <= PPP_IDLE;
         endcase
      end
   end

   // Memory array updates: page commit and erase
   always_ff @(posedge mclk_i)
   begin
      if (state_r == PPP_ERASE)
      begin
         flash_mem[erase_idx_r] <= 16'hFFFF;
         if (erase_idx_r < FA'(1 << EA) &&
             cfg_hi_eff_r[ppp_pkg::HI_EEPROM_KEEP])
            ee_mem[erase_idx_r[EA-1:0]] <= 8'hFF;
      end
      else if (state_r == PPP_WRITE && cnt_r == 32'(WRITE_CYCLES))
      begin
         if (cmd_r == ppp_pkg::CMD_WR_FLASH)
         begin
            for (int i = 0; i < (1<<ppp_pkg::FLASH_WORD_BITS); i++)
               flash_mem[{addr_r[FA-1:ppp_pkg::FLASH_WORD_BITS],
                  ppp_pkg::FLASH_WORD_BITS'(i)}] <= flash_buf[i];
         end
         else if (cmd_r == ppp_pkg::CMD_WR_EE)
         begin
            for (int j = 0; j < (1<<ppp_pkg::EE_BYTE_BITS); j++)
               ee_mem[{addr_r[EA-1:ppp_pkg::EE_BYTE_BITS],
                  ppp_pkg::EE_BYTE_BITS'(j)}] <= ee_buf[j];
         end
      end
   end

   // Fuse latching: at power-up, on mode entry and on mode exit
   always_ff @(posedge mclk_i)
   begin
      if (sys_rst_i)
      begin
         cfg_hi_eff_r <= ppp_pkg::CFG_HI_RST;
         cfg_lo_eff_r <= ppp_pkg::CFG_LO_RST;
      end
      else if (prog_mode_i != mode_d_r)
      begin
         cfg_hi_eff_r <= cfg_hi_r;
         cfg_lo_eff_r <= cfg_lo_r;
      end
      else
         // Keep fuse follows the stored value at once
         cfg_hi_eff_r[ppp_pkg::HI_EEPROM_KEEP] <=
            cfg_hi_r[ppp_pkg::HI_EEPROM_KEEP];
   end

   // Calibration copy into the oscillator trim during reset
   always_ff @(posedge mclk_i)
   begin
      if (sys_rst_i)
         trim_r <= CAL_BYTE;
   end

   // Read data capture on output enable falling edge
   always_ff @(posedge mclk_i)
   begin
      if (sys_rst_i)
         rd_r <= 8'h00;
      else if (prog_mode_i && oe_fall)
      begin
         case (cmd_r)
            ppp_pkg::CMD_RD_SIG:
               if (byte_select_first_i)
                  rd_r <= CAL_BYTE;
               else if (addr_r[1:0] == ppp_pkg::SIG_ADDR_0)
                  rd_r <= SIG_BYTE0;
               else if (addr_r[1:0] == ppp_pkg::SIG_ADDR_1)
                  rd_r <= SIG_BYTE1;
               else if (addr_r[1:0] == ppp_pkg::SIG_ADDR_2)
                  rd_r <= SIG_BYTE2;
               else
                  rd_r <= 8'hFF;
            ppp_pkg::CMD_RD_FUSE:
               if (byte_select_second_i && byte_select_first_i)
                  rd_r <= cfg_hi_r;
               else if (byte_select_second_i)
                  rd_r <= cfg_ext_r;
               else if (byte_select_first_i)
                  rd_r <= lock_r;
               else
                  rd_r <= cfg_lo_r;
            ppp_pkg::CMD_RD_FLASH:
               rd_r <= byte_select_first_i ?
                  flash_mem[addr_r[FA-1:0]][15:8] :
                  flash_mem[addr_r[FA-1:0]][7:0];
            ppp_pkg::CMD_RD_EE:
               rd_r <= ee_mem[addr_r[EA-1:0]];
            default:
               rd_r <= 8'hFF;
         endcase
      end
   end

   // Outputs
   assign data_o              = rd_r;
   assign data_oe_o           = prog_mode_i & ~out_enable_n_i;
   assign ready_busy_out_o    = (state_r == PPP_IDLE);
   assign cfg_hi_eff_o        = cfg_hi_eff_r;
   assign cfg_lo_eff_o        = cfg_lo_eff_r;
   assign eeprom_keep_o       = cfg_hi_eff_r[ppp_pkg::HI_EEPROM_KEEP];
   assign osc_trim_register_o = trim_r;

endmodule // ppp_port

`default_nettype wire

// *** ppp_port_props.sv ***
// Concurrent checks on the parallel programming port pins.
// Assumes it is bound onto ppp_port and shares its single clock.
`timescale 1ns/1ns
`default_nettype none
module ppp_port_props
#(
   parameter int         WRITE_CYCLES = 4,
   parameter logic [7:0] CAL_BYTE     = 8'h80
)
(
   // Clock, reset and mode
   input wire logic       mclk_i,
   input wire logic       sys_rst_i,
   input wire logic       prog_mode_i,
   // Programmer pins
   input wire logic       load_strobe_i,
   input wire logic       action_select_hi_i,
   input wire logic       action_select_lo_i,
   input wire logic       write_n_i,
   input wire logic       out_enable_n_i,
   input wire logic [7:0] data_i,
   // Device outputs
   input wire logic [7:0] data_o,
   input wire logic       data_oe_o,
   input wire logic       ready_busy_out_o,
   input wire logic [7:0] cfg_hi_eff_o,
   input wire logic [7:0] cfg_lo_eff_o,
   input wire logic [7:0] osc_trim_register_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (sys_rst_i);
   logic [7:0]  cmd_r;  // Shadow of the last command byte
   logic [13:0] busy_r; // Busy cycles so far, wide enough for erase
   // Shadow the command so busy length can be judged per command
   always_ff @(posedge mclk_i)
   begin
      if (sys_rst_i)
         cmd_r <= 8'h00;
      else if ($rose(load_strobe_i) && prog_mode_i && ready_busy_out_o &&
               {action_select_hi_i, action_select_lo_i} == 2'h2)
         cmd_r <= data_i;
   end
   // Count busy cycles; cleared while ready
   always_ff @(posedge mclk_i)
   begin
      if (sys_rst_i || ready_busy_out_o)
         busy_r <= 14'h0000;
      else
         busy_r <= busy_r + 14'h0001;
   end
   a_bus_drive: assert property (
      data_oe_o == (prog_mode_i && !out_enable_n_i))
      else $error("data bus enable wrong");
   a_busy_start: assert property (
      prog_mode_i && ready_busy_out_o && $fell(write_n_i) &&
      cmd_r inside {8'h80, 8'h40, 8'h20, 8'h10, 8'h11} |->
      ##[1:2] !ready_busy_out_o)
      else $error("write strobe did not start busy");
   a_busy_len: assert property (
      $rose(ready_busy_out_o) && cmd_r != 8'h80 |->
      busy_r >= WRITE_CYCLES - 1 && busy_r <= WRITE_CYCLES + 2)
      else $error("write busy length wrong");
   a_erase_len: assert property (
      $rose(ready_busy_out_o) && cmd_r == 8'h80 |->
      busy_r inside {[14'h1FFE:14'h2002]})
      else $error("erase busy length wrong");
   a_busy_cause: assert property (
      $fell(ready_busy_out_o) |-> !$past(write_n_i))
      else $error("busy without write strobe");
   a_cfg_hold: assert property (
      prog_mode_i && $past(prog_mode_i) && $past(prog_mode_i, 3) &&
      $past(prog_mode_i, 2) |->
      // Keep bit left out: it follows the stored fuse at once
      $stable({cfg_hi_eff_o[7:4], cfg_hi_eff_o[2:0]}) &&
      $stable(cfg_lo_eff_o))
      else $error("fuse outputs moved inside mode");
   a_trim_set: assert property (
      $fell(sys_rst_i) |-> osc_trim_register_o == CAL_BYTE)
      else $error("trim not loaded in reset");
   a_reset_state: assert property (
      $fell(sys_rst_i) |-> ready_busy_out_o && data_o == 8'h00 &&
      cfg_hi_eff_o == ppp_pkg::CFG_HI_RST &&
      cfg_lo_eff_o == ppp_pkg::CFG_LO_RST)
      else $error("state after reset wrong");
   a_read_hold: assert property (
      out_enable_n_i && $past(out_enable_n_i) &&
      $past(out_enable_n_i, 2) && !$past(sys_rst_i) |-> $stable(data_o))
      else $error("read data moved without strobe");
endmodule // ppp_port_props
bind ppp_port ppp_port_props #(.WRITE_CYCLES(WRITE_CYCLES),
   .CAL_BYTE(CAL_BYTE)) ppp_port_props_inst (.mclk_i(mclk_i),
   .sys_rst_i(sys_rst_i), .prog_mode_i(prog_mode_i),
   .load_strobe_i(load_strobe_i), .action_select_hi_i(action_select_hi_i),
   .action_select_lo_i(action_select_lo_i), .write_n_i(write_n_i),
   .out_enable_n_i(out_enable_n_i), .data_i(data_i), .data_o(data_o),
   .data_oe_o(data_oe_o), .ready_busy_out_o(ready_busy_out_o),
   .cfg_hi_eff_o(cfg_hi_eff_o), .cfg_lo_eff_o(cfg_lo_eff_o),
   .osc_trim_register_o(osc_trim_register_o));
`default_nettype wire

// *** ppp_prog.sv ***
// Model of the external programmer that drives the parallel pins.
// Assumes tasks are called at a falling clock edge.
`timescale 1ns/1ns
`default_nettype none
module ppp_prog
(
   // Clock and device answers
   input  wire logic       mclk_i,
   input  wire logic       ready_i,
   input  wire logic [7:0] dev_data_i,
   input  wire logic       dev_oe_i,
   // Control pins
   output logic            prog_mode_o,
   output logic            load_o,
   output logic            act_hi_o,
   output logic            act_lo_o,
   output logic            bs1_o,
   output logic            bs2_o,
   output logic            page_o,
   output logic            wr_n_o,
   output logic            oe_n_o,
   // Resolved data bus
   output logic [7:0]      bus_o
);
   logic [7:0] drv_r; // Byte the programmer puts on the bus
   // A released, undriven bus shows junk so stale data never passes
   assign bus_o = dev_oe_i ? dev_data_i : (oe_n_o ? drv_r : ~drv_r);
   initial
   begin
      {prog_mode_o, load_o, act_hi_o, act_lo_o, bs1_o, bs2_o} = 6'h00;
      {page_o, wr_n_o, oe_n_o, drv_r} = {3'h3, 8'h00};
   end
   // Every control pulse lasts at least the minimum width
   task automatic hold();
      repeat (ppp_pkg::MIN_PULSE_CYC) @(negedge mclk_i);
   endtask
   // Mode change with the all-zero entry pattern on the pins
   task automatic enter(input logic on);
      {page_o, act_hi_o, act_lo_o, bs1_o} = 4'h0;
      hold();
      prog_mode_o = on;
      hold();
   endtask
   // Load a byte; the select pins choose what it is
   task automatic load(input logic [1:0] act, input logic b1,
                       input logic [7:0] val);
      // Second byte select parked low, else a data byte lands in the
      // second high byte left over from an earlier read
      {act_hi_o, act_lo_o, bs1_o, bs2_o, drv_r} = {act, b1, 1'b0, val};
      hold();
      load_o = 1'b1;
      hold();
      load_o = 1'b0;
   endtask
   // Page latch pulse
   task automatic page();
      page_o = 1'b1;
      hold();
      page_o = 1'b0;
   endtask
   // Write strobe, then wait for ready under a bound
   task automatic strobe(input logic b1, input logic b2,
                         output logic busy, output logic ok);
      int n;
      {bs1_o, bs2_o, wr_n_o} = {b1, b2, 1'b0};
      repeat (3) @(negedge mclk_i);
      busy = !ready_i;
      hold();
      wr_n_o = 1'b1;
      n = 0;
      while (!ready_i && n < 9000)
      begin
         @(negedge mclk_i);
         n++;
      end
      ok = ready_i;
   endtask
   // Output enable pulse; returns the byte on the bus
   task automatic read(input logic b1, input logic b2,
                       output logic [7:0] val, output logic oe);
      {bs1_o, bs2_o, oe_n_o} = {b1, b2, 1'b0};
      hold();
      {val, oe} = {bus_o, dev_oe_i};
      oe_n_o = 1'b1;
      @(negedge mclk_i);
   endtask
endmodule // ppp_prog
`default_nettype wire

// *** tb_ppp_port.sv ***
// Self-checking testbench for the parallel programming port.
// Assumes ppp_pkg, ppp_port, its checker and the programmer model.
`timescale 1ns/1ns
`default_nettype none
module tb_ppp_port;
   logic       mclk, rst, pm, ls, ah, al, b1, b2, pl, wn, on, doe;
   logic       rdy, keep, busy, ok, oe;
   logic [7:0] bus, dd, hi, lo, trim, v;
   int         err_total, checked, cyc;
   always #5 mclk = ~mclk;
   ppp_port #(.WRITE_CYCLES(4), .SIG_BYTE0(8'hA5), .SIG_BYTE1(8'h5A),
      .SIG_BYTE2(8'h3C), .CAL_BYTE(8'h80)) ppp_port_inst (.mclk_i(mclk),
      .sys_rst_i(rst), .prog_mode_i(pm), .load_strobe_i(ls),
      .action_select_hi_i(ah), .action_select_lo_i(al),
      .byte_select_first_i(b1), .byte_select_second_i(b2),
      .page_latch_strobe_i(pl), .write_n_i(wn), .out_enable_n_i(on),
      .data_i(bus), .data_o(dd), .data_oe_o(doe), .ready_busy_out_o(rdy),
      .cfg_hi_eff_o(hi), .cfg_lo_eff_o(lo), .eeprom_keep_o(keep),
      .osc_trim_register_o(trim));
   ppp_prog ppp_prog_inst (.mclk_i(mclk), .ready_i(rdy), .dev_data_i(dd),
      .dev_oe_i(doe), .prog_mode_o(pm), .load_o(ls), .act_hi_o(ah),
      .act_lo_o(al), .bs1_o(b1), .bs2_o(b2), .page_o(pl), .wr_n_o(wn),
      .oe_n_o(on), .bus_o(bus));
   // Compare and count
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         err_total++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   // Load a command, then run it with the write strobe
   task automatic run(input logic [7:0] c, input logic [7:0] d,
                      input logic s1);
      ppp_prog_inst.load(2'h2, 1'b0, c);
      ppp_prog_inst.load(2'h1, 1'b0, d);
      ppp_prog_inst.strobe(s1, 1'b0, busy, ok);
      check({busy, ok}, 2'h3);
   endtask
   // Read with a command and address low byte
   task automatic rd(input logic [7:0] c, input logic [7:0] a,
                     input logic s1, input logic s2, input logic [7:0] e);
      ppp_prog_inst.load(2'h2, 1'b0, c);
      ppp_prog_inst.load(2'h0, 1'b0, a);
      ppp_prog_inst.read(s1, s2, v, oe);
      check({oe, v}, {1'b1, e});
      check(doe, 1'b0);
   endtask
   // Signature and calibration space
   task automatic t_signature();
      rd(8'h08, 8'h00, 1'b0, 1'b0, 8'hA5);
      rd(8'h08, 8'h01, 1'b0, 1'b0, 8'h5A);
      rd(8'h08, 8'h02, 1'b0, 1'b0, 8'h3C);
      rd(8'h08, 8'h00, 1'b1, 1'b0, 8'h80);
   endtask
   // Fuse writes deferred to mode exit, keep fuse at once
   task automatic t_fuses();
      rd(8'h04, 8'h00, 1'b0, 1'b0, 8'h62);
      rd(8'h04, 8'h00, 1'b1, 1'b1, 8'h99);
      run(8'h40, 8'hE2, 1'b0);
      run(8'h40, 8'h91, 1'b1);
      check({keep, hi, lo}, 17'h09162);
      rd(8'h04, 8'h00, 1'b0, 1'b0, 8'hE2);
      ppp_prog_inst.enter(1'b0);
      check({hi, lo}, 16'h91E2);
      ppp_prog_inst.enter(1'b1);
   endtask
   // Page writes, erase, then a lock that freezes the fuses
   task automatic t_memory();
      ppp_prog_inst.load(2'h2, 1'b0, 8'h10);
      ppp_prog_inst.load(2'h0, 1'b0, 8'h3F);
      ppp_prog_inst.load(2'h1, 1'b0, 8'hAA);
      ppp_prog_inst.load(2'h1, 1'b1, 8'h55);
      ppp_prog_inst.page();
      run(8'h10, 8'hAA, 1'b0);
      rd(8'h02, 8'h3F, 1'b0, 1'b0, 8'hAA);
      rd(8'h02, 8'h3F, 1'b1, 1'b0, 8'h55);
      ppp_prog_inst.load(2'h2, 1'b0, 8'h11);
      ppp_prog_inst.load(2'h0, 1'b0, 8'h02);
      ppp_prog_inst.load(2'h1, 1'b0, 8'h5A);
      ppp_prog_inst.page();
      run(8'h11, 8'h5A, 1'b0);
      rd(8'h03, 8'h02, 1'b0, 1'b0, 8'h5A);
      run(8'h80, 8'h00, 1'b0);
      check({keep, hi, lo}, 17'h091E2);
      rd(8'h02, 8'h3F, 1'b0, 1'b0, 8'hFF);
      rd(8'h03, 8'h02, 1'b0, 1'b0, 8'h5A);
      run(8'h20, 8'hFE, 1'b0);
      run(8'h40, 8'h00, 1'b0);
      rd(8'h04, 8'h00, 1'b0, 1'b0, 8'hE2);
      rd(8'h04, 8'h00, 1'b1, 1'b0, 8'hFE);
      rd(8'h08, 8'h01, 1'b0, 1'b0, 8'h5A);
   endtask
   // Report counts and the verdict, then stop
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // Cut a hang short
   always @(posedge mclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 40000)
      begin
         err_total++;
         complete_run();
      end
   end
   initial
   begin
      {mclk, rst, err_total, checked, cyc} = {2'h3, 32'h0, 32'h0, 32'h0};
      repeat (11) @(negedge mclk);
      rst = 1'b0;
      @(negedge mclk);
      check({rdy, doe, hi, lo, trim}, 26'h2996280);
      ppp_prog_inst.enter(1'b1);
      t_signature();
      t_fuses();
      t_memory();
      complete_run();
   end
endmodule // tb_ppp_port
`default_nettype wire
